// ### shared/input_func_pkg.sv
package input_func_pkg;

   // ----------------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // ----------------------------------------------------------------------
   localparam logic [7:0] TERM_FUNC_BASE = 8'h00;  // six words, terminal 1 at 0x00 .. terminal 6 at 0x14
   localparam logic [7:0] POLARITY_OFF = 8'h18;
   localparam logic [7:0] RAMP_METHOD_OFF = 8'h1C;
   localparam logic [7:0] RESUME_MODE_OFF = 8'h20;
   localparam logic [7:0] RESUME_DELAY_OFF = 8'h24;
   localparam logic [7:0] STATUS_OFF = 8'h28;

   // ----------------------------------------------------------------------
   // field layout and reset values
   // ----------------------------------------------------------------------
   localparam int NUM_TERMS = 6;
   localparam int FUNC_W = 8;
   localparam int METHOD_W = 2;
   localparam int DELAY_W = 16;
   localparam logic [FUNC_W-1:0] FUNC_RST = 8'hFF;      // no function assigned
   localparam logic [NUM_TERMS-1:0] POLARITY_RST = 6'h00;
   localparam logic [METHOD_W-1:0] METHOD_RST = 2'h0;
   localparam logic RESUME_MODE_RST = 1'b0;
   localparam logic [DELAY_W-1:0] DELAY_RST = 16'h0000;
   localparam int ST_MSET_BIT = 0;
   localparam int ST_RSET_BIT = 1;
   localparam int ST_OUTEN_BIT = 2;
   localparam int ST_COAST_BIT = 3;
   localparam int ST_WAIT_BIT = 4;
   localparam int ST_TERM_LSB = 8;

   // ----------------------------------------------------------------------
   // function option codes
   // ----------------------------------------------------------------------
   localparam logic [FUNC_W-1:0] OPT_MOTOR_SET = 8'h08;
   localparam logic [FUNC_W-1:0] OPT_RAMP_SET = 8'h09;
   localparam logic [FUNC_W-1:0] OPT_COAST_STOP = 8'h0B;
   localparam logic [METHOD_W-1:0] METHOD_TERMINAL = 2'h0;

   // ----------------------------------------------------------------------
   // timing: resume delay counts in ticks of 100 us
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int RESUME_TICK_NS = 100_000;
   localparam int RESUME_TICK_CYC = RESUME_TICK_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 12;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      ST_NORMAL = 2'b00,
      ST_COAST = 2'b01,
      ST_WAIT = 2'b10
   } coast_state_t;

endpackage : input_func_pkg

// ### src/drive_input_function_select.sv
`timescale 1ns/100ps

module drive_input_function_select
   import input_func_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // axi4-lite write address and data
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // axi4-lite write response
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // axi4-lite read
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // intelligent input terminals and drive status
   input wire logic [NUM_TERMS-1:0] TERM_IN,
   input wire logic RUN_CMD,
   input wire logic MOTOR_STOPPED,
   // selections handed to the frequency generator
   output logic MOTOR_SET_SEL,
   output logic RAMP_SET_SEL,
   output logic OUTPUT_ENABLE,
   output logic RESUME_START,
   output logic RESUME_FROM_SPEED
);

   // ----------------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------------
   // true when any terminal carrying this option code is at its active level
   function automatic logic func_hit(input logic [NUM_TERMS-1:0][FUNC_W-1:0] codes,
                                     input logic [NUM_TERMS-1:0] lvl,
                                     input logic [FUNC_W-1:0] opt);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_TERMS; i++) begin
         hit = hit | ((codes[i] == opt) & lvl[i]);
      end
      return hit;
   endfunction : func_hit
   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return res;
   endfunction : wmerge
   // address decode shared by the read and write paths
   function automatic logic is_mapped(input logic [7:0] addr);
      return (addr[1:0] == 2'b00) && (addr <= STATUS_OFF);
   endfunction : is_mapped

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   logic [NUM_TERMS-1:0][FUNC_W-1:0] func_q;
   logic [NUM_TERMS-1:0] polarity_q, sync1_q, sync2_q, level_act;
   logic [METHOD_W-1:0] method_q;
   logic [DELAY_W-1:0] delay_q, dly_cnt_q;
   logic resume_mode_q, set_hit, ramp_hit, coast_hit, wr_fire;
   logic mset_q, rset_q, out_en_q, resume_q, from_speed_q;
   coast_state_t state_q;
   logic [TICK_W-1:0] presc_q;
   logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q, rdata_q, rd_word;
   logic [3:0] w_strb_q;
   logic [1:0] bresp_q, rresp_q;

   // ----------------------------------------------------------------------
   // terminal sampling
   // ----------------------------------------------------------------------
   // two flops per terminal; only the second stage feeds any decision
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= TERM_IN;
         sync2_q <= sync1_q;
      end
   end
   // polarity bit set means normally closed: open contact is active
   assign level_act = sync2_q ^ polarity_q;
   assign set_hit = func_hit(func_q, level_act, OPT_MOTOR_SET);
   assign ramp_hit = func_hit(func_q, level_act, OPT_RAMP_SET);
   assign coast_hit = func_hit(func_q, level_act, OPT_COAST_STOP);

   // ----------------------------------------------------------------------
   // motor set and ramp set selection
   // ----------------------------------------------------------------------
   // motor set is frozen while turning so the generator never swaps mid-run
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         mset_q <= 1'b0;
      end else if (MOTOR_STOPPED) begin
         mset_q <= set_hit;
      end
   end
   // ramp set follows the input only while the method is terminal, with no wait for the ramp to end
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rset_q <= 1'b0;
      end else begin
         rset_q <= ramp_hit && (method_q == METHOD_TERMINAL);
      end
   end

   // ----------------------------------------------------------------------
   // coast stop sequencing
   // ----------------------------------------------------------------------
   // output gate, resume delay and resume pulse
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state_q <= ST_NORMAL;
         out_en_q <= 1'b1;
         resume_q <= 1'b0;
         from_speed_q <= 1'b0;
         presc_q <= '0;
         dly_cnt_q <= '0;
      end else begin
         resume_q <= 1'b0;
         case (state_q)
            ST_NORMAL: begin
               out_en_q <= !coast_hit;
               if (coast_hit) begin
                  state_q <= ST_COAST;
               end
            end
            ST_COAST: begin
               if (!coast_hit) begin
                  if (!RUN_CMD) begin
                     state_q <= ST_NORMAL;  // nothing to resume
                     out_en_q <= 1'b1;
                  end else if (delay_q == '0) begin
                     state_q <= ST_NORMAL;
                     out_en_q <= 1'b1;
                     resume_q <= 1'b1;
                     from_speed_q <= resume_mode_q;
                  end else begin
                     state_q <= ST_WAIT;
                     dly_cnt_q <= delay_q;
                     presc_q <= '0;
                  end
               end
            end
            ST_WAIT: begin
               if (coast_hit) begin
                  state_q <= ST_COAST;
               end else if (!RUN_CMD) begin
                  state_q <= ST_NORMAL;
                  out_en_q <= 1'b1;
               end else if (dly_cnt_q == '0) begin
                  state_q <= ST_NORMAL;
                  out_en_q <= 1'b1;
                  resume_q <= 1'b1;
                  from_speed_q <= resume_mode_q;
               end else if (presc_q == TICK_W'(RESUME_TICK_CYC - 1)) begin
                  presc_q <= '0;
                  dly_cnt_q <= dly_cnt_q - 1'b1;
               end else begin
                  presc_q <= presc_q + 1'b1;
               end
            end
            default: begin
               state_q <= ST_COAST;  // fail safe: keep output off
               out_en_q <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------------
   assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
   // address and data are taken in either order and held until both are here
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && awready_q) begin
            aw_hold_q <= 1'b1;
            awready_q <= 1'b0;
            aw_addr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && wready_q) begin
            w_hold_q <= 1'b1;
            wready_q <= 1'b0;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
         end
         if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end
   // configuration registers; status is read-only and ignores writes
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         func_q <= {NUM_TERMS{FUNC_RST}};
         polarity_q <= POLARITY_RST;
         method_q <= METHOD_RST;
         resume_mode_q <= RESUME_MODE_RST;
         delay_q <= DELAY_RST;
      end else if (wr_fire) begin
         for (int i = 0; i < NUM_TERMS; i++) begin
            if (aw_addr_q == TERM_FUNC_BASE + 8'(4 * i)) begin
               func_q[i] <= FUNC_W'(wmerge({24'h00_0000, func_q[i]}, w_data_q, w_strb_q));
            end
         end
         // a lane left out of the strobe keeps its old bits, so polarity needs lane 0
         case (aw_addr_q)
            POLARITY_OFF: polarity_q <= NUM_TERMS'(wmerge({26'h000_0000, polarity_q}, w_data_q, w_strb_q));
            RAMP_METHOD_OFF: method_q <= METHOD_W'(wmerge({30'h0000_0000, method_q}, w_data_q, w_strb_q));
            RESUME_MODE_OFF: resume_mode_q <= 1'(wmerge({31'h0000_0000, resume_mode_q}, w_data_q, w_strb_q));
            RESUME_DELAY_OFF: delay_q <= DELAY_W'(wmerge({16'h0000, delay_q}, w_data_q, w_strb_q));
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------------
   // read word mux; unused bits read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      for (int i = 0; i < NUM_TERMS; i++) begin
         if (S_AXI_ARADDR == TERM_FUNC_BASE + 8'(4 * i)) begin
            rd_word[FUNC_W-1:0] = func_q[i];
         end
      end
      case (S_AXI_ARADDR)
         POLARITY_OFF: rd_word[NUM_TERMS-1:0] = polarity_q;
         RAMP_METHOD_OFF: rd_word[METHOD_W-1:0] = method_q;
         RESUME_MODE_OFF: rd_word[0] = resume_mode_q;
         RESUME_DELAY_OFF: rd_word[DELAY_W-1:0] = delay_q;
         STATUS_OFF: begin
            rd_word[ST_MSET_BIT] = mset_q;
            rd_word[ST_RSET_BIT] = rset_q;
            rd_word[ST_OUTEN_BIT] = out_en_q;
            rd_word[ST_COAST_BIT] = (state_q == ST_COAST);
            rd_word[ST_WAIT_BIT] = (state_q == ST_WAIT);
            rd_word[ST_TERM_LSB +: NUM_TERMS] = sync2_q;
         end
         default: ;
      endcase
   end
   // one read at a time; data and RVALID are registered on the same edge that takes the address
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else if (S_AXI_ARVALID && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= is_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // outputs, all from flops
   // ----------------------------------------------------------------------
   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = wready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;
   assign MOTOR_SET_SEL = mset_q;
   assign RAMP_SET_SEL = rset_q;
   assign OUTPUT_ENABLE = out_en_q;
   assign RESUME_START = resume_q;
   assign RESUME_FROM_SPEED = from_speed_q;

   // ----------------------------------------------------------------------
   // assertions and covers
   // ----------------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   a_mset_frozen_run: assert property (!MOTOR_STOPPED |=> $stable(mset_q))
      else $error("motor set changed while running");
   a_mset_follows_stop: assert property (MOTOR_STOPPED |=> mset_q == $past(set_hit))
      else $error("motor set does not follow input when stopped");
   a_ramp_follows_in: assert property (##1 rset_q == $past(ramp_hit && method_q == METHOD_TERMINAL))
      else $error("ramp set late or wrong");
   a_ramp_method_gate: assert property (method_q != METHOD_TERMINAL |=> !rset_q)
      else $error("ramp set active with non-terminal method");
   a_coast_cuts_out: assert property (coast_hit |=> !out_en_q && !resume_q)
      else $error("output not cut on coast stop");
   a_no_resume_idle: assert property (state_q == ST_WAIT && !coast_hit && !RUN_CMD |=> !resume_q && out_en_q)
      else $error("resume without run command");
   a_zero_delay_now: assert property (state_q == ST_COAST && !coast_hit && RUN_CMD && delay_q == '0
                                      |=> resume_q && out_en_q)
      else $error("zero delay resume did not happen at once");
   a_resume_mode_pick: assert property ($rose(resume_q) |-> from_speed_q == $past(resume_mode_q))
      else $error("resume start mode wrong");
   a_normal_passes: assert property (state_q == ST_NORMAL && !coast_hit |=> out_en_q)
      else $error("output blocked in normal operation");
   a_sync_two_stage: assert property (##2 sync2_q == $past(TERM_IN, 2))
      else $error("terminal sync depth wrong");
   a_wait_holds_off: assert property (state_q == ST_WAIT && dly_cnt_q != '0 && RUN_CMD |=> !out_en_q)
      else $error("output on before delay elapsed");

   c_coast_resume: cover property (state_q == ST_WAIT ##1 resume_q);
   c_mset_switch: cover property (MOTOR_STOPPED && set_hit ##1 mset_q);
   c_ramp_on: cover property ($rose(rset_q));
   c_nc_coast: cover property (polarity_q != '0 && coast_hit);
endmodule : drive_input_function_select

// ### verification/contact_bank.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// contact bank standing on the terminal strip
// ---------------------------------------------------------------
module contact_bank
   import input_func_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // contact positions asked for by the bench, 1 = closed
   input wire logic [NUM_TERMS-1:0] closed,
   // terminal levels seen by the drive
   output logic [NUM_TERMS-1:0] term_level
);
   // a contact settles one cycle after it is moved, on the drive's sampling edge, which still sees the old level;
   // closed pulls the input high, open reads low, so a normally closed setting sees open as active
   always @(posedge ref_clk) begin
      term_level <= closed;
   end
endmodule : contact_bank

// ### verification/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
// ---------------------------------------------------------------
// bench top
// ---------------------------------------------------------------
module tb_top
   import input_func_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1;
   logic [7:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, last_resp;
   logic [NUM_TERMS-1:0] closed = '0, term_in;
   logic run_cmd = 1'b0, motor_stopped = 1'b1;
   logic mset, rset, oen, rstart, rspeed, seen_speed = 1'b0;
   int num_errors = 0, n_tests = 0, pulses = 0;

   // 40 MHz clock
   initial forever #12.5 clk = ~clk;

   drive_input_function_select uut (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TERM_IN(term_in),
      .RUN_CMD(run_cmd), .MOTOR_STOPPED(motor_stopped), .MOTOR_SET_SEL(mset), .RAMP_SET_SEL(rset),
      .OUTPUT_ENABLE(oen), .RESUME_START(rstart), .RESUME_FROM_SPEED(rspeed));

   contact_bank contacts (.ref_clk(clk), .closed(closed), .term_level(term_in));

   // resume pulses are one cycle wide, so they are counted on every edge
   always @(posedge clk) begin
      if (rstart === 1'b1) begin
         pulses <= pulses + 1;
         seen_speed <= rspeed;
      end
   end

   task automatic tally_and_finish;
      if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   // one write; awaddr and wdata are each held until their own ready
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 50);
      last_resp = bresp;
      bready <= 1'b0;
      if (n >= 50) num_errors++;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 50);
      d = rdata;
      last_resp = rresp;
      rready <= 1'b0;
      if (n >= 50) num_errors++;
   endtask : rd

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_cyc

   // ramp-set selection expected from method code and terminal level
   function automatic logic exp_ramp(input logic [METHOD_W-1:0] m, input logic v);
      return v && (m == METHOD_TERMINAL);
   endfunction : exp_ramp

   // watchdog: the longest path is a few thousand cycles of resume delay
   initial begin
      wait_cyc(60000);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      int base, tm, tr, tc, cyc, p0;
      logic [31:0] d;
      logic v;
      base = $urandom(32'h6b50);
      wait_cyc(20);
      rst <= 1'b0;
      // reset values and refused accesses
      rd(TERM_FUNC_BASE, d);
      `CHK("func reset", FUNC_RST, d[7:0])
      rd(STATUS_OFF, d);
      `CHK("status enable", 1'b1, d[ST_OUTEN_BIT])
      rd(8'h2C, d);
      `CHK("unmapped resp", RESP_SLVERR, last_resp)
      `CHK("unmapped data", 32'h0000_0000, d)
      wr(8'h30, 32'h0000_000B);
      `CHK("unmapped wr", RESP_SLVERR, last_resp)
      // coast-stop moved over all six terminals, run inactive
      for (int k = 0; k < NUM_TERMS; k++) begin
         wr(TERM_FUNC_BASE + 8'(k * 4), {24'h0, OPT_COAST_STOP});
         closed[k] <= 1'b1;
         wait_cyc(6);
         `CHK("coast cut", 1'b0, oen)
         closed[k] <= 1'b0;
         wait_cyc(6);
         `CHK("coast release", 1'b1, oen)
         wr(TERM_FUNC_BASE + 8'(k * 4), {24'h0, FUNC_RST});
      end
      `CHK("no resume", 0, pulses)
      base = $urandom % NUM_TERMS;
      tm = base; tr = (base + 1) % NUM_TERMS; tc = (base + 2) % NUM_TERMS;
      wr(TERM_FUNC_BASE + 8'(tm * 4), {24'h0, OPT_MOTOR_SET});
      wr(TERM_FUNC_BASE + 8'(tr * 4), {24'h0, OPT_RAMP_SET});
      wr(TERM_FUNC_BASE + 8'(tc * 4), {24'h0, OPT_COAST_STOP});
      // motor set follows its input only while stopped
      motor_stopped <= 1'b0; closed[tm] <= 1'b1;
      wait_cyc(6);
      `CHK("mset running", 1'b0, mset)
      motor_stopped <= 1'b1;
      wait_cyc(6);
      `CHK("mset second", 1'b1, mset)
      motor_stopped <= 1'b0; closed[tm] <= 1'b0;
      wait_cyc(6);
      `CHK("mset kept", 1'b1, mset)
      motor_stopped <= 1'b1;
      wait_cyc(6);
      `CHK("mset first", 1'b0, mset)
      // ramp set against every method code, fixed levels then random levels
      for (int i = 0; i < 12; i++) begin
         v = (i < 8) ? i[2] : 1'($urandom);  // every method code seen with both levels first
         wr(RAMP_METHOD_OFF, 32'(i % 4));
         closed[tr] <= v;
         wait_cyc(6);
         `CHK("ramp sel", exp_ramp(METHOD_W'(i % 4), v), rset)
      end
      // coast stop on a normally closed contact with run active, both resume modes
      run_cmd <= 1'b1; closed[tc] <= 1'b1;
      wr(POLARITY_OFF, 32'(1 << tc));
      wait_cyc(6);
      `CHK("nc idle", 1'b1, oen)
      for (int mode = 0; mode < 2; mode++) begin
         wr(RESUME_MODE_OFF, 32'(mode));
         p0 = pulses;
         closed[tc] <= 1'b0;
         wait_cyc(6);
         `CHK("nc coast", 1'b0, oen)
         closed[tc] <= 1'b1;
         wait_cyc(6);
         `CHK("resume pulse", p0 + 1, pulses)
         `CHK("resume enable", 1'b1, oen)
         `CHK("resume mode", 1'(mode), seen_speed)
      end
      // one tick of resume delay: output stays cut, then resumes
      wr(RESUME_DELAY_OFF, 32'h0000_0001);
      rd(RESUME_DELAY_OFF, d);
      `CHK("delay readback", 32'h0000_0001, d)
      closed[tc] <= 1'b0;
      wait_cyc(6);
      closed[tc] <= 1'b1;
      p0 = pulses; cyc = 0;
      while (pulses == p0 && cyc < 5000) begin
         @(posedge clk);
         cyc++;
         if (cyc == 100) `CHK("delay cut", 1'b0, oen)
      end
      `CHK("delay span", 1'b1, cyc >= RESUME_TICK_CYC && cyc <= RESUME_TICK_CYC + 12)
      // release without run: output gate opens, no resume
      wr(RESUME_DELAY_OFF, 32'h0000_0000);
      run_cmd <= 1'b0; closed[tc] <= 1'b0;
      p0 = pulses;
      wait_cyc(6);
      closed[tc] <= 1'b1;
      wait_cyc(6);
      `CHK("stop no pulse", p0, pulses)
      `CHK("stop enable", 1'b1, oen)
      tally_and_finish();
   end
endmodule : tb_top
